// ---- hw/fsp_segment_config.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_segment_config
  import fsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        dualPartition,
  output fsp_cfgreq_s      cfgReq,
  input  wire logic [23:0] cfgRdData,
  input  wire logic [23:0] busAddr,
  input  wire logic [31:0] busWrData,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic      [31:0] busRdData,
  input  wire logic        chkValid,
  input  wire logic [12:0] chkPage,
  input  wire logic        chkConfig,
  output logic             chkDone,
  output logic             chkGrant,
  output fsp_prot_s        prot,
  output logic      [1:0]  bootModeSelect,
  output logic      [2:0]  contextOneSelect,
  output logic      [2:0]  contextTwoSelect,
  output logic             cpuRelease,
  output logic             activePartition
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic fsp_level_e level2(input logic [1:0] f);
    if (f == 2'h3) begin
      level2 = LVL_NONE;
    end else if (f == 2'h2) begin
      level2 = LVL_STANDARD;
    end else begin
      level2 = LVL_HIGH;
    end
  endfunction

  function automatic logic seqValid(input logic [23:0] w);
    seqValid = (w[`FSP_IBSEQ_HI:`FSP_IBSEQ_LO] == ~w[`FSP_BSEQ_HI:0]);
  endfunction

  // Word list of one partition, boot mode word is shared
  function automatic logic [23:0] wordAddr(input logic [2:0] idx, input logic part);
    logic [23:0] base;
    base = `FSP_ADDR_SEC;
    case (idx)
      3'h0: base = `FSP_ADDR_SEC;
      3'h1: base = `FSP_ADDR_BSLIM;
      3'h2: base = `FSP_ADDR_DEVOPT;
      3'h3: base = `FSP_ADDR_ALTCTX;
      3'h4: base = `FSP_ADDR_BTSEQ;
      default: base = `FSP_ADDR_BOOTMODE;
    endcase
    if (part && idx != `FSP_IDX_LAST) begin
      wordAddr = base + `FSP_PART2_OFFSET;
    end else begin
      wordAddr = base;
    end
  endfunction

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SEQ0,
    ST_SEQ1,
    ST_LOAD,
    ST_WAIT,
    ST_DONE
  } fsp_state_e;

  fsp_state_e  state;
  fsp_state_e  next_state;
  logic        issued;
  logic        dataVal;
  logic [2:0]  idx;
  logic [23:0] seq0;
  logic        loadPart;
  logic        swapped;
  logic [23:0] wSec;
  logic [23:0] wBslim;
  logic [23:0] wDevopt;
  logic [23:0] wAltctx;
  logic [23:0] wBtseq;
  logic [23:0] wBootmode;

  wire logic seq0Ok = seqValid(seq0);
  wire logic seq1Ok = seqValid(cfgRdData);
  // Tie or no valid number keeps partition one, the safe default
  wire logic pick2 = seq1Ok &&
                     (!seq0Ok || cfgRdData[`FSP_BSEQ_HI:0] < seq0[`FSP_BSEQ_HI:0]);

  always_comb begin
    next_state = state;
    case (state)
      ST_SEQ0: if (dataVal) next_state = ST_SEQ1;
      ST_SEQ1: if (dataVal) next_state = ST_LOAD;
      ST_LOAD: if (dataVal && idx == `FSP_IDX_LAST) next_state = ST_WAIT;
      ST_WAIT: next_state = ST_DONE;
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_SEQ0;
    endcase
  end

  // One read in flight at a time: the next waits until the answer is taken
  wire logic doIssue = !issued && !dataVal && state != ST_WAIT && state != ST_DONE;
  wire logic [23:0] issueAddr = (state == ST_LOAD) ? wordAddr(idx, loadPart) :
                                wordAddr(3'h4, state == ST_SEQ1);
  // Memory answers in the cycle after the strobe
  wire logic capSeq0 = dataVal && state == ST_SEQ0;
  wire logic capSeq1 = dataVal && state == ST_SEQ1;
  wire logic capLoad = dataVal && state == ST_LOAD;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_SEQ0;
    end else if (state == ST_SEQ0 && !dualPartition) begin
      state <= ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      issued  <= 1'b0;
      dataVal <= 1'b0;
      cfgReq  <= '0;
    end else begin
      dataVal <= issued;
      issued <= doIssue && !(state == ST_SEQ0 && !dualPartition);
      cfgReq.rdEn <= doIssue && !(state == ST_SEQ0 && !dualPartition);
      cfgReq.addr <= issueAddr;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx      <= 3'h0;
      seq0     <= 24'h000000;
      loadPart <= 1'b0;
    end else begin
      if (capSeq0) seq0 <= cfgRdData;
      if (capSeq1) loadPart <= pick2;
      if (capLoad) idx <= idx + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Shadow words, written only during the load
  // ----------------------------------------------------------------
  wire logic       capEn  = capLoad;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wSec      <= `FSP_WORD_RST;
      wBslim    <= `FSP_WORD_RST;
      wDevopt   <= `FSP_WORD_RST;
      wAltctx   <= `FSP_WORD_RST;
      wBtseq    <= `FSP_WORD_RST;
      wBootmode <= `FSP_WORD_RST;
    end else if (capEn) begin
      case (idx)
        3'h0: wSec <= cfgRdData;
        3'h1: wBslim <= cfgRdData;
        3'h2: wDevopt <= cfgRdData;
        3'h3: wAltctx <= cfgRdData;
        3'h4: wBtseq <= cfgRdData;
        default: wBootmode <= cfgRdData;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [2:0] cssField = wSec[`FSP_CSS_HI:`FSP_CSS_LO];
  wire fsp_level_e cfgLevel = (cssField == 3'h7) ? LVL_NONE :
                              (cssField == 3'h6) ? LVL_STANDARD :
                              cssField[2] ? LVL_ENHANCED : LVL_HIGH;
  wire logic [12:0] lastBootPage = ~wBslim[`FSP_BSLIM_HI:0];
  wire logic bootOn = !wSec[`FSP_BOOT_SEG_DISABLE_BIT];

  fsp_prot_s next_prot;
  always_comb begin
    next_prot.bootLevel      = level2(wSec[`FSP_BSS_HI:`FSP_BSS_LO]);
    next_prot.generalLevel   = level2(wSec[`FSP_GSS_HI:`FSP_GSS_LO]);
    next_prot.configLevel    = cfgLevel;
    next_prot.bootSegOn      = bootOn;
    next_prot.bootWriteOk    = wSec[`FSP_BOOT_SEG_WRITE_LOCK_BIT];
    next_prot.generalWriteOk = wSec[`FSP_GENERAL_SEG_WRITE_LOCK_BIT];
    next_prot.configWriteOk  = wSec[`FSP_CONFIG_SEG_WRITE_LOCK_BIT];
    next_prot.pwmKeyLock     = wDevopt[`FSP_PWM_WRITE_KEY_LOCK_BIT];
  end

  // Reserved bits are the programmer's job; they are carried, never checked
  wire logic inBoot = bootOn && (chkPage < lastBootPage);
  wire logic next_grant = chkConfig ? wSec[`FSP_CONFIG_SEG_WRITE_LOCK_BIT] :
                          inBoot ? wSec[`FSP_BOOT_SEG_WRITE_LOCK_BIT] :
                          wSec[`FSP_GENERAL_SEG_WRITE_LOCK_BIT];
  wire logic loaded = state == ST_DONE;

  // Until the load completes every write is refused and prot is held at all zeros, every level none
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prot       <= '0;
      cpuRelease <= 1'b0;
    end else begin
      prot       <= loaded ? next_prot : '0;
      cpuRelease <= loaded;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bootModeSelect   <= 2'h0;
      contextOneSelect <= 3'h0;
      contextTwoSelect <= 3'h0;
    end else begin
      bootModeSelect   <= wBootmode[`FSP_BTMODE_HI:0];
      contextOneSelect <= wAltctx[`FSP_CTX1_HI:0];
      contextTwoSelect <= wAltctx[`FSP_CTX2_HI:`FSP_CTX2_LO];
    end
  end

  // ----------------------------------------------------------------
  // Query port
  // ----------------------------------------------------------------
  // Grant follows the released flag so it never runs ahead of prot
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chkDone  <= 1'b0;
      chkGrant <= 1'b0;
    end else begin
      chkDone  <= chkValid;
      chkGrant <= chkValid && cpuRelease && next_grant;
    end
  end

  // ----------------------------------------------------------------
  // Soft swap: flips the active partition, shadow words stay put
  // ----------------------------------------------------------------
  wire logic ctrlHit = busWr && busAddr == `FSP_ADDR_CTRL;
  wire logic swapReq = ctrlHit && busWrData[`FSP_SWAP_BIT] && loaded && dualPartition;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      activePartition <= 1'b0;
      swapped         <= 1'b0;
    end else if (swapReq) begin
      activePartition <= !activePartition;
      swapped         <= 1'b1;
    end else if (capSeq1) begin
      activePartition <= pick2;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  wire logic [31:0] statusWord = {27'h0000000, swapped, seqValid(wBtseq),
                                  dualPartition, activePartition, loaded};
  logic [31:0] next_rd;
  always_comb begin
    next_rd = 32'h00000000;
    case (busAddr)
      `FSP_ADDR_SEC:      next_rd = {8'h00, wSec};
      `FSP_ADDR_BSLIM:    next_rd = {8'h00, wBslim};
      `FSP_ADDR_DEVOPT:   next_rd = {8'h00, wDevopt};
      `FSP_ADDR_ALTCTX:   next_rd = {8'h00, wAltctx};
      `FSP_ADDR_BTSEQ:    next_rd = {8'h00, wBtseq};
      `FSP_ADDR_BOOTMODE: next_rd = {8'h00, wBootmode};
      `FSP_ADDR_STATUS:   next_rd = statusWord;
      default:            next_rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busRdData <= 32'h00000000;
    end else begin
      busRdData <= busRd ? next_rd : 32'h00000000;
    end
  end

endmodule

// ---- hw/fsp_defines.svh ----
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ----------------------------------------------------------------
// Configuration word addresses (partition one)
// ----------------------------------------------------------------
`define FSP_ADDR_SEC      24'h002b80
`define FSP_ADDR_BSLIM    24'h002b90
`define FSP_ADDR_DEVOPT   24'h002bac
`define FSP_ADDR_ALTCTX   24'h002bb0
`define FSP_ADDR_BTSEQ    24'h002bfc
`define FSP_ADDR_BOOTMODE 24'h801000
`define FSP_PART2_OFFSET  24'h400000

// ----------------------------------------------------------------
// Own control and status registers
// ----------------------------------------------------------------
`define FSP_ADDR_CTRL     24'h002bc0
`define FSP_ADDR_STATUS   24'h002bc4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FSP_BOOT_SEG_WRITE_LOCK_BIT      0
`define FSP_BSS_HI        2
`define FSP_BSS_LO        1
`define FSP_BOOT_SEG_DISABLE_BIT      3
`define FSP_GENERAL_SEG_WRITE_LOCK_BIT      5
`define FSP_GSS_HI        7
`define FSP_GSS_LO        6
`define FSP_CONFIG_SEG_WRITE_LOCK_BIT      8
`define FSP_CSS_HI        11
`define FSP_CSS_LO        9
`define FSP_BSLIM_HI      12
`define FSP_PWM_WRITE_KEY_LOCK_BIT   0
`define FSP_BSEQ_HI       11
`define FSP_IBSEQ_HI      23
`define FSP_IBSEQ_LO      12
`define FSP_BTMODE_HI     1
`define FSP_CTX1_HI       2
`define FSP_CTX2_HI       6
`define FSP_CTX2_LO       4
`define FSP_SWAP_BIT      0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define FSP_WORD_RST      24'hffffff
`define FSP_NUM_WORDS     3'h6
`define FSP_IDX_LAST      3'h5

`endif

// ---- hw/fsp_pkg.sv ----
package fsp_pkg;

  typedef enum logic [1:0] {
    LVL_NONE,
    LVL_STANDARD,
    LVL_ENHANCED,
    LVL_HIGH
  } fsp_level_e;

  typedef struct packed {
    fsp_level_e bootLevel;
    fsp_level_e generalLevel;
    fsp_level_e configLevel;
    logic       bootSegOn;
    logic       bootWriteOk;
    logic       generalWriteOk;
    logic       configWriteOk;
    logic       pwmKeyLock;
  } fsp_prot_s;

  typedef struct packed {
    logic [23:0] addr;
    logic        rdEn;
  } fsp_cfgreq_s;

endpackage

// ---- tb/fsp_cfg_mem.sv ----
`timescale 1ns/1ps
// ------
// Config memory model
// ------
module fsp_cfg_mem
  import fsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  fsp_cfgreq_s      cfgReq,
  output logic      [23:0] cfgRdData
);
  logic [23:0] mem [0:127];
  logic [6:0]  slot;
  // Partition two sits 0x400000 higher, so address bit 22 picks it
  assign slot = {cfgReq.addr[22], cfgReq.addr[7:2]};
  // Answer after one cycle; otherwise flip so stale data never holds still
  always_ff @(posedge clk_sys) begin
    cfgRdData <= cfgReq.rdEn ? mem[slot] : ~cfgRdData;
  end
endmodule

// ---- tb/fsp_segment_config_chk.sv ----
`timescale 1ns/1ps
module fsp_segment_config_chk
  import fsp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input fsp_cfgreq_s      cfgReq,
  input wire logic [23:0] cfgRdData,
  input wire logic        chkValid,
  input wire logic [12:0] chkPage,
  input wire logic        chkConfig,
  input wire logic        chkDone,
  input wire logic        chkGrant,
  input fsp_prot_s        prot,
  input wire logic [1:0]  bootModeSelect,
  input wire logic        cpuRelease
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ------
  // Words seen on the config bus
  // ------
  logic        rdPend;
  logic [23:0] secW, limW, optW, bootW;
  logic        inBoot;
  assign inBoot = !secW[3] && chkPage < ~limW[12:0];
  // Address still holds in the data cycle, so it names the word
  always_ff @(posedge clk_sys) begin
    rdPend <= cfgReq.rdEn;
    if (rdPend && cfgReq.addr[21:0] == 22'h002b80) secW <= cfgRdData;
    if (rdPend && cfgReq.addr[21:0] == 22'h002b90) limW <= cfgRdData;
    if (rdPend && cfgReq.addr[21:0] == 22'h002bac) optW <= cfgRdData;
    if (rdPend && cfgReq.addr == 24'h801000) bootW <= cfgRdData;
  end
  function automatic fsp_level_e lv2(input logic [1:0] b);
    return (b == 2'b11) ? LVL_NONE : b[1] ? LVL_STANDARD : LVL_HIGH;
  endfunction
  function automatic fsp_level_e lv3(input logic [2:0] b);
    return (b == 3'b111) ? LVL_NONE : (b == 3'b110) ? LVL_STANDARD :
      b[2] ? LVL_ENHANCED : LVL_HIGH;
  endfunction
  // ------
  // Properties
  // ------
  sequence s_cfgAsk; chkValid && cpuRelease && chkConfig; endsequence
  sequence s_bootAsk; chkValid && cpuRelease && !chkConfig && inBoot; endsequence
  sequence s_genAsk; chkValid && cpuRelease && !chkConfig && !inBoot; endsequence
  property p_bootLvl; cpuRelease |-> prot.bootLevel == lv2(secW[2:1]); endproperty
  property p_genLvl; cpuRelease |-> prot.generalLevel == lv2(secW[7:6]); endproperty
  property p_cfgLvl; cpuRelease |-> prot.configLevel == lv3(secW[11:9]); endproperty
  property p_bits;
    cpuRelease |-> {prot.bootSegOn, prot.bootWriteOk, prot.generalWriteOk,
      prot.configWriteOk} == {!secW[3], secW[0], secW[5], secW[8]};
  endproperty
  property p_opts;
    cpuRelease |-> prot.pwmKeyLock == optW[0] && bootModeSelect == bootW[1:0];
  endproperty
  property p_hold; cpuRelease |=> cpuRelease && $stable(prot); endproperty
  property p_early; chkValid && !cpuRelease |=> chkDone && !chkGrant; endproperty
  property p_cfgGrant; s_cfgAsk |=> chkDone && chkGrant == secW[8]; endproperty
  property p_bootGrant; s_bootAsk |=> chkDone && chkGrant == secW[0]; endproperty
  property p_genGrant; s_genAsk |=> chkDone && chkGrant == secW[5]; endproperty
  a_bootLvl: assert property (p_bootLvl) else $error("boot level");
  a_genLvl: assert property (p_genLvl) else $error("general level");
  a_cfgLvl: assert property (p_cfgLvl) else $error("config level");
  a_bits: assert property (p_bits) else $error("lock bits");
  a_opts: assert property (p_opts) else $error("options");
  a_hold: assert property (p_hold) else $error("hold");
  a_early: assert property (p_early) else $error("early grant");
  a_cfgGrant: assert property (p_cfgGrant) else $error("config grant");
  a_bootGrant: assert property (p_bootGrant) else $error("boot grant");
  a_genGrant: assert property (p_genGrant) else $error("general grant");
endmodule
bind fsp_segment_config fsp_segment_config_chk fsp_segment_config_chk_inst (.*);

// ---- tb/fsp_segment_config_test.sv ----
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_segment_config_test
  import fsp_pkg::*;
;
  logic        clk_sys, nrst, dualPartition, busWr, busRd, chkValid, chkConfig;
  logic        chkDone, chkGrant, cpuRelease, activePartition, act, rdDly;
  logic [1:0]  bootModeSelect;
  logic [2:0]  ctx1, ctx2;
  logic [12:0] chkPage;
  logic [23:0] busAddr, cfgRdData, secW, limW, optW, bootW, sq1, sq2;
  logic [31:0] busWrData, busRdData, s;
  logic [31:0] expQ [$];
  fsp_cfgreq_s cfgReq;
  fsp_prot_s   prot;
  int          errCount, nCompared, cyc;
  fsp_segment_config fsp_segment_config_inst (.clk_sys(clk_sys), .nrst(nrst),
    .dualPartition(dualPartition), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
    .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
    .busRdData(busRdData), .chkValid(chkValid), .chkPage(chkPage),
    .chkConfig(chkConfig), .chkDone(chkDone), .chkGrant(chkGrant), .prot(prot),
    .bootModeSelect(bootModeSelect), .contextOneSelect(ctx1), .contextTwoSelect(ctx2),
    .cpuRelease(cpuRelease), .activePartition(activePartition));
  fsp_cfg_mem fsp_cfg_mem_inst (.clk_sys(clk_sys), .cfgReq(cfgReq), .cfgRdData(cfgRdData));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Trailing edge keeps a following strobe off this time step
  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    expQ.push_back(e);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clk_sys);
    busRd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    busAddr <= a;
    busWrData <= d;
    busWr <= 1'b1;
    @(posedge clk_sys);
    busWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic ask(input logic [12:0] p, input logic c);
    chkValid <= 1'b1;
    chkPage <= p;
    chkConfig <= c;
    @(posedge clk_sys);
    chkValid <= 1'b0;
    @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rdDly) check("busRdData", expQ.pop_front(), busRdData);
    rdDly <= busRd;
    cyc++;
    if (cyc > 3000) begin
      errCount++;
      conclude();
    end
  end
  initial begin
    {nrst, dualPartition, busWr, busRd, chkValid, chkConfig, rdDly} = 7'h0;
    busAddr = 24'h0;
    busWrData = 32'h0;
    chkPage = 13'h0;
    s = 32'h82d66dd4;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      nrst <= 1'b0;
      dualPartition <= i[2];
      s = nx(s);
      secW = s[23:0];
      secW[11:9] = i[2:0];
      secW[7:6] = i[1:0];
      secW[2:1] = ~i[1:0];
      secW[3] = (i == 3);
      s = nx(s);
      limW = {11'h0, s[12:0]};
      optW = s[31:8] | 24'h4;
      sq1 = {~s[11:0] ^ {11'h0, i == 6}, s[11:0]};
      sq2 = {~s[27:16] ^ {11'h0, i == 5}, s[27:16]};
      bootW = {22'h3fffff, s[5:4]};
      for (int p = 0; p < 2; p++) begin
        fsp_cfg_mem_inst.mem[{p[0], 6'h20}] = secW;
        fsp_cfg_mem_inst.mem[{p[0], 6'h24}] = limW;
        fsp_cfg_mem_inst.mem[{p[0], 6'h2b}] = optW;
        fsp_cfg_mem_inst.mem[{p[0], 6'h2c}] = s[23:0];
        fsp_cfg_mem_inst.mem[{p[0], 6'h3f}] = p ? sq2 : sq1;
      end
      fsp_cfg_mem_inst.mem[0] = bootW;
      act = i[2] && (i == 6 || (i != 5 && sq2[11:0] < sq1[11:0]));
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      ask(13'h0, 1'b0);
      for (int n = 0; n < 60 && cpuRelease !== 1'b1; n++) @(posedge clk_sys);
      check("cpuRelease", 32'h1, cpuRelease);
      check("activePartition", act, activePartition);
      check("contextOneSelect", s[2:0], ctx1);
      check("contextTwoSelect", s[6:4], ctx2);
      rd(`FSP_ADDR_SEC, secW);
      rd(`FSP_ADDR_BSLIM, limW);
      rd(`FSP_ADDR_DEVOPT, optW);
      rd(`FSP_ADDR_BTSEQ, act ? sq2 : sq1);
      rd(`FSP_ADDR_BOOTMODE, bootW);
      wr(`FSP_ADDR_SEC, s);
      rd(`FSP_ADDR_SEC, secW);
      rd(24'h000010, 32'h0);
      for (int j = 0; j < 4; j++) ask(~limW[12:0] - 13'h1 + j[0], j[1]);
      wr(`FSP_ADDR_CTRL, 32'h1);
      check("activePartition", act ^ i[2], activePartition);
      rd(`FSP_ADDR_SEC, secW);
      rd(`FSP_ADDR_STATUS, {27'h0, i[2], 1'b1, i[2], act ^ i[2], 1'b1});
      $display("test %0d done", i);
    end
    repeat (3) @(posedge clk_sys);
    check("expQ", 32'h0, expQ.size());
    conclude();
  end
endmodule
